// ===== rtl/bridge_reset_power_state_ctrl.sv
// reset and power-state sequencing for a two-port bridge
// assumes config writes are byte strobes synchronous to i_clk
`timescale 1ns/100ps
`default_nettype none
`include "rst_pwr_defines.svh"

// What this block does
// - power-state writes to D1 or D2 are dropped; state keeps its current value
// - entering D3hot with clock-control enable stops and holds clocks low
// - D3hot to D0 restarts clocks and runs chip reset without secondary reset
// - only D0, D3hot and D3cold exist; registers via enhanced capability list
// - in D3hot the secondary bus may be placed in B2
// - downstream power events are never forwarded through the bridge
// - primary reset floats control outputs, drives secondary ad/cbe/par low, chip-resets and loads defaults
// - primary reset edges may be asynchronous to both bus clocks
// - secondary reset asserts whenever primary reset is asserted
// - after primary release shift mask in, then wait 100 us before release
// - secondary reset bit forces reset; release 100 us after it clears
// - chip reset write asserts secondary reset and sets secondary reset bit
// - after chip reset, hold reset until bit cleared; the mask is not shifted again
// - chip reset defaults the config registers, not the sequencer state, and floats primary and secondary control outputs
// - chip reset bit self-clears within 20 clocks of its write
// - no access is answered while chip reset runs
// - secondary reset floats secondary control outputs and grants at once
// - secondary reset drives address/data, command and parity low
// - secondary reset flushes posted-write and delayed buffers
// - reset by the bit still answers primary configuration accesses
// - after shift, float mask pins; release only if reset bit is clear
// - secondary clocks start only after primary reset is released
module bridge_reset_power_state_ctrl
	import rst_pwr_pkg::*;
(
	input  wire logic                  i_clk,          // primary bus clock
	input  wire logic                  i_nrst,         // primary reset, async
	input  wire logic                  i_cfg_wr,       // config byte write
	input  wire logic                  i_cfg_rd,       // config byte read
	input  wire logic [7:0]            i_cfg_addr,     // config byte offset
	input  wire rst_pwr_pkg::cfg_byte_t i_cfg_wdata,   // write byte
	input  wire logic                  i_bus_power_clock_ctrl_en, // pin
	input  wire logic                  i_mask_in,      // serial clock mask
	output logic [7:0]                 o_cfg_rdata,    // read byte
	output logic                       o_cfg_ack,      // access answered
	output logic                       o_sec_rst_n,    // secondary reset
	output logic                       o_sec_clk_en,   // secondary clocks run
	output logic                       o_mask_pins_oe, // mask-load pins drive
	output logic                       o_pri_oe,       // primary outputs on
	output logic                       o_sec_ctrl_oe,  // sec control/grant on
	output logic                       o_sec_ad_low,   // sec ad/cbe/par low
	output logic                       o_buf_flush,    // flush buffers
	output logic                       o_b2_state,     // secondary bus in B2
	output logic [1:0]                 o_pwr_state     // current power state
);
	// ********************************
	// reset release
	// ********************************
	logic rs1_r, rs2_r;
	// two stages so release is clean; assertion bypasses the clock
	always_ff @(posedge i_clk or negedge i_nrst)
		if (!i_nrst)
		begin
			rs1_r <= 1'b0;
			rs2_r <= 1'b0;
		end
		else
		begin
			rs1_r <= 1'b1;
			rs2_r <= rs1_r;
		end
	wire logic rst_n = rs2_r;

	// ********************************
	// chip reset pulse
	// ********************************
	logic [4:0] chip_cnt_r;
	logic [1:0] pwr_r;
	logic       chip_act_r;
	logic       chip_go;
	wire logic  wr_ok = i_cfg_wr && !chip_act_r;
	wire logic [1:0] pm_wr = i_cfg_wdata[1:0];
	// wake decode reads the live state so back-to-back writes see D3hot
	assign chip_go = (wr_ok && i_cfg_addr == `OFS_DIAG_CTRL
		&& i_cfg_wdata[`BIT_CHIP_RST])
		|| (wr_ok && i_cfg_addr == `OFS_PM_CSR
		&& pwr_r == `PWR_D3HOT && pm_wr == `PWR_D0);

	// counts a fixed chip reset below the 20-clock limit
	always_ff @(posedge i_clk or negedge rst_n)
		if (!rst_n)
		begin
			chip_act_r <= 1'b0;
			chip_cnt_r <= 5'h00;
		end
		else if (chip_go)
		begin
			chip_act_r <= 1'b1;
			chip_cnt_r <= 5'(`CHIP_RST_CYC);
		end
		else if (chip_act_r)
		begin
			chip_cnt_r <= chip_cnt_r - 5'h01;
			if (chip_cnt_r == 5'h01)
				chip_act_r <= 1'b0;
		end
	wire logic chip_diag_r_set = wr_ok && i_cfg_addr == `OFS_DIAG_CTRL
		&& i_cfg_wdata[`BIT_CHIP_RST];
	logic diag_origin_r; // chip reset started by the diagnostic bit
	always_ff @(posedge i_clk or negedge rst_n)
		if (!rst_n)
			diag_origin_r <= 1'b0;
		else if (chip_go)
			diag_origin_r <= chip_diag_r_set;
	wire logic soft_rst = chip_act_r;

	// ********************************
	// configuration registers
	// ********************************
	logic [15:0] bctl_r;
	// registers default on primary reset or chip reset
	always_ff @(posedge i_clk or negedge rst_n)
		if (!rst_n)
		begin
			bctl_r <= 16'h0000;
			pwr_r  <= `PWR_D0;
		end
		else if (soft_rst)
		begin
			bctl_r <= 16'h0000;
			pwr_r  <= `PWR_D0;
			if (diag_origin_r)
				bctl_r[`BIT_SEC_RST] <= 1'b1;
		end
		else if (chip_diag_r_set)
			bctl_r[`BIT_SEC_RST] <= 1'b1;
		else if (wr_ok)
		begin
			if (i_cfg_addr == `OFS_BRIDGE_CTRL)
				bctl_r[7:0] <= i_cfg_wdata;
			if (i_cfg_addr == `OFS_BRIDGE_CTRL_HI)
				bctl_r[15:8] <= i_cfg_wdata;
			// D1/D2 unsupported, so the write is dropped
			if (i_cfg_addr == `OFS_PM_CSR
				&& (pm_wr == `PWR_D0 || pm_wr == `PWR_D3HOT))
				pwr_r <= pm_wr;
		end
	wire logic sec_bit = bctl_r[`BIT_SEC_RST];

	// ********************************
	// register read port
	// ********************************
	// bit-driven secondary reset leaves config reachable
	always_ff @(posedge i_clk or negedge rst_n)
		if (!rst_n)
		begin
			o_cfg_ack   <= 1'b0;
			o_cfg_rdata <= 8'h00;
		end
		else
		begin
			o_cfg_ack <= (i_cfg_wr || i_cfg_rd) && !chip_act_r;
			unique case (i_cfg_addr)
				`OFS_BRIDGE_CTRL:    o_cfg_rdata <= bctl_r[7:0];
				`OFS_BRIDGE_CTRL_HI: o_cfg_rdata <= bctl_r[15:8];
				`OFS_DIAG_CTRL:      o_cfg_rdata <= {7'h00, chip_act_r};
				`OFS_PM_CSR:         o_cfg_rdata <= {6'h00, pwr_r};
				default:             o_cfg_rdata <= 8'h00;
			endcase
		end

	// ********************************
	// secondary reset sequencer
	// ********************************
	sec_rst_e    st_r;
	logic [3:0]  shift_cnt_r;
	logic [15:0] mask_r;
	logic [`CNT_W-1:0] dly_r;
	logic        sec_rst_r;
	// mask shift only follows a real primary release; chip reset reuses it
	always_ff @(posedge i_clk or negedge rst_n)
		if (!rst_n)
		begin
			st_r        <= SR_SHIFT;
			shift_cnt_r <= 4'h0;
			mask_r      <= 16'h0000;
			dly_r       <= '0;
			sec_rst_r   <= 1'b1;
		end
		else
			unique case (st_r)
				SR_SHIFT:
				begin
					mask_r      <= {mask_r[14:0], i_mask_in};
					shift_cnt_r <= shift_cnt_r + 4'h1;
					if (shift_cnt_r == 4'(`MASK_BITS - 1))
						st_r <= SR_HOLD;
				end
				SR_HOLD:
					if (!sec_bit && !soft_rst)
					begin
						st_r  <= SR_WAIT;
						dly_r <= `CNT_W'(`SEC_RST_DELAY_CYC);
					end
				SR_WAIT:
					if (sec_bit)
						st_r <= SR_HOLD;
					else if (dly_r == `CNT_W'(1))
					begin
						st_r      <= SR_RUN;
						sec_rst_r <= 1'b0;
					end
					else
						dly_r <= dly_r - `CNT_W'(1);
				SR_RUN:
					if (sec_bit)
					begin
						st_r      <= SR_HOLD;
						sec_rst_r <= 1'b1;
					end
			endcase
	wire logic sec_rst_now = sec_rst_r || sec_bit;

	// ********************************
	// pin controls
	// ********************************
	// D3hot-exit chip reset keeps the secondary reset pin idle
	always_ff @(posedge i_clk or negedge rst_n)
		if (!rst_n)
		begin
			o_sec_rst_n    <= 1'b0;
			o_sec_clk_en   <= 1'b0;
			o_mask_pins_oe <= 1'b0;
			o_pri_oe       <= 1'b0;
			o_sec_ctrl_oe  <= 1'b0;
			o_sec_ad_low   <= 1'b1;
			o_buf_flush    <= 1'b1;
			o_b2_state     <= 1'b0;
			o_pwr_state    <= `PWR_D0;
		end
		else
		begin
			o_sec_rst_n    <= !sec_rst_now;
			o_sec_clk_en   <= !(pwr_r == `PWR_D3HOT
				&& i_bus_power_clock_ctrl_en);
			o_mask_pins_oe <= st_r == SR_SHIFT;
			o_pri_oe       <= !soft_rst;
			o_sec_ctrl_oe  <= !sec_rst_now && !soft_rst;
			o_sec_ad_low   <= sec_rst_now;
			o_buf_flush    <= sec_rst_now || soft_rst;
			o_b2_state     <= pwr_r == `PWR_D3HOT
				&& i_bus_power_clock_ctrl_en;
			o_pwr_state    <= pwr_r;
		end
	// power events from downstream have no path here; no port exists.

	// ********************************
	// checks
	// ********************************
	d1d2_drop_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(wr_ok && i_cfg_addr == `OFS_PM_CSR && pwr_r == `PWR_D0
		&& (pm_wr == `PWR_D1 || pm_wr == `PWR_D2) && !soft_rst)
		|=> pwr_r == `PWR_D0)
		else $error("unsupported power state accepted");
	clk_stop_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(pwr_r == `PWR_D3HOT && i_bus_power_clock_ctrl_en) |=> !o_sec_clk_en)
		else $error("clocks not stopped in D3hot");
	chip_len_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		chip_go |-> ##[1:20] !chip_act_r)
		else $error("chip reset overran");
	no_ack_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		$past(chip_act_r) |-> !o_cfg_ack)
		else $error("access answered in chip reset");
	sec_float_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		!o_sec_rst_n |-> !o_sec_ctrl_oe && o_sec_ad_low)
		else $error("secondary outputs driven in reset");
	set_bit_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		chip_diag_r_set |=> sec_bit)
		else $error("chip reset left reset bit clear");
	hold_rst_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		sec_bit |=> !o_sec_rst_n)
		else $error("secondary reset released with bit set");
	wait_dly_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(st_r == SR_HOLD ##1 st_r == SR_WAIT) |-> sec_rst_r [*8])
		else $error("secondary reset released early");
	flush_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		sec_rst_now |=> o_buf_flush)
		else $error("buffers not flushed");
	cfg_live_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(i_cfg_rd && !chip_act_r) |=> o_cfg_ack)
		else $error("config access lost in reset");
	rel_c: cover property (@(posedge i_clk) disable iff (!rst_n)
		st_r == SR_WAIT ##1 st_r == SR_RUN);
	chip_c: cover property (@(posedge i_clk) disable iff (!rst_n)
		chip_go ##1 chip_act_r);
	d3_c: cover property (@(posedge i_clk) disable iff (!rst_n)
		pwr_r == `PWR_D3HOT ##1 pwr_r == `PWR_D0);
	// mask pins drive only while the mask is being clocked in
	mask_oe_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(st_r != SR_SHIFT) |=> !o_mask_pins_oe)
		else $error("mask pins driven after shift");
	wake_c: cover property (@(posedge i_clk) disable iff (!rst_n)
		chip_go && !chip_diag_r_set ##1 chip_act_r && o_sec_rst_n);
endmodule
`default_nettype wire

// ===== rtl/rst_pwr_defines.svh
// constants for the reset and power-state sequencer
// assumes a 40 MHz core clock and byte-wide configuration writes
`ifndef RST_PWR_DEFINES_SVH
`define RST_PWR_DEFINES_SVH

`define OFS_BRIDGE_CTRL     8'h3e
`define OFS_BRIDGE_CTRL_HI  8'h3f
`define OFS_DIAG_CTRL       8'h41
`define OFS_PM_CSR          8'h44
`define BIT_SEC_RST         6
`define BIT_CHIP_RST        0
`define PWR_D0              2'h0
`define PWR_D1              2'h1
`define PWR_D2              2'h2
`define PWR_D3HOT           2'h3
`define CLK_MHZ             40
`define SEC_RST_DELAY_US    100
`define SEC_RST_DELAY_CYC   (`SEC_RST_DELAY_US * `CLK_MHZ)
`define CHIP_RST_CYC        16
`define CHIP_RST_MAX_CYC    20
`define MASK_BITS           16
`define CNT_W               13

`endif

// ===== rtl/rst_pwr_pkg.sv
// types for the reset and power-state sequencer
// assumes rst_pwr_defines.svh is available on the include path
`default_nettype none
`include "rst_pwr_defines.svh"
package rst_pwr_pkg;
	typedef logic [1:0] pwr_state_t;
	typedef logic [7:0] cfg_byte_t;
	typedef enum logic [1:0] {SR_HOLD, SR_SHIFT, SR_WAIT, SR_RUN} sec_rst_e;
endpackage
`default_nettype wire

// ===== verification/mask_source.sv
// far-side model: serial clock mask source feeding the block
// assumes the block samples one mask bit a clock, starting two clocks after reset release
`timescale 1ns/100ps
`default_nettype none
module mask_source
(
	input  wire logic        i_clk,  // primary clock
	input  wire logic        i_nrst, // primary reset, active low
	input  wire logic [15:0] i_mask, // mask pattern to shift out
	output logic             o_bit   // serial mask bit
);
	logic [4:0] pos_r;
	logic       junk_r;

	// frame position counts once per release, then parks
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			pos_r <= 5'h00;
		else if (pos_r != 5'h14)
			pos_r <= pos_r + 5'h01;
	end

	// outside the frame the line toggles so stale bits never look valid
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			junk_r <= 1'b0;
		else
			junk_r <= ~junk_r;
	end

	assign o_bit = (pos_r >= 5'h02 && pos_r < 5'h12) ?
		i_mask[pos_r - 5'h02] : junk_r;
endmodule
`default_nettype wire

// ===== verification/tb_bridge_reset_power_state_ctrl.sv
// self-checking bench for the reset and power-state sequencer
// assumes design, package and mask_source are compiled before this file
`timescale 1ns/100ps
`default_nettype none
module tb_bridge_reset_power_state_ctrl;
	import rst_pwr_pkg::*;
	logic        i_clk = 1'b0, i_nrst = 1'b0, wr = 1'b0, rd = 1'b0;
	logic        pcc_en = 1'b0;
	logic [7:0]  addr = 8'h00;
	cfg_byte_t   wdata = 8'h00;
	logic [15:0] mask_val = 16'h0000, nt;
	logic [7:0]  rdata;
	logic        mbit, ack, srst_n, clk_en, moe, pri_oe, ctrl_oe;
	logic        ad_low, flush, b2, bad;
	pwr_state_t  pwr;
	logic [15:0] note_q[$];
	logic [31:0] rng = 32'h0000004d;
	int          err_count = 0, check_count = 0, n;

	initial
	begin
		forever #12.5 i_clk = ~i_clk;
	end

	bridge_reset_power_state_ctrl DUT (.i_clk(i_clk), .i_nrst(i_nrst),
		.i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_addr(addr),
		.i_cfg_wdata(wdata), .i_bus_power_clock_ctrl_en(pcc_en),
		.i_mask_in(mbit), .o_cfg_rdata(rdata), .o_cfg_ack(ack),
		.o_sec_rst_n(srst_n), .o_sec_clk_en(clk_en), .o_mask_pins_oe(moe),
		.o_pri_oe(pri_oe), .o_sec_ctrl_oe(ctrl_oe), .o_sec_ad_low(ad_low),
		.o_buf_flush(flush), .o_b2_state(b2), .o_pwr_state(pwr));
	mask_source PARTNER (.i_clk(i_clk), .i_nrst(i_nrst), .i_mask(mask_val),
		.o_bit(mbit));

	// ****************************************
	// shared tasks
	// ****************************************
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	task automatic check(input logic ok, input string msg);
	begin
		check_count++;
		if (ok !== 1'b1)
		begin
			err_count++;
			$display("MISMATCH at %0t: %s", $time, msg);
		end
	end
	endtask

	task automatic print_verdict();
	begin
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask

	// one strobe; refused strobes leave no note, so a stray answer shows
	task automatic cfg(input logic w, input logic [7:0] a, m, e,
		input logic take);
	begin
		@(negedge i_clk);
		rng = xs(rng);
		wr = w;
		rd = ~w;
		addr = a;
		wdata = w ? e : rng[7:0];
		if (take)
			note_q.push_back(w ? 16'h0000 : {m, e});
		@(negedge i_clk);
		wr = 1'b0;
		rd = 1'b0;
	end
	endtask

	// cycles until secondary reset lifts, bounded
	task automatic wait_rel(output int c);
	begin
		c = 0;
		while (srst_n !== 1'b1)
		begin
			@(posedge i_clk);
			#1;
			c++;
			if (c > 6000)
			begin
				check(1'b0, "release timeout");
				print_verdict();
			end
		end
	end
	endtask

	// answer watcher: looks mid-cycle, where ack and rdata stand settled
	always @(negedge i_clk)
	begin
		if (ack === 1'b1 && note_q.size() == 0)
			check(1'b0, "stray answer");
		else if (ack === 1'b1)
		begin
			nt = note_q.pop_front();
			check(((rdata ^ nt[7:0]) & nt[15:8]) === 8'h00, "answer");
		end
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		repeat (20) @(negedge i_clk);
		check(srst_n === 1'b0 && pri_oe === 1'b0, "reset out");
		check(ad_low === 1'b1 && flush === 1'b1 && ctrl_oe === 1'b0, "float");
		check(clk_en === 1'b0 && moe === 1'b0, "clk in reset");
		mask_val = rng[15:0] ^ 16'h5a3c;
		i_nrst = 1'b1;
		repeat (4) @(negedge i_clk);
		check(moe === 1'b1, "mask pins not driven in shift");
		wait_rel(n);
		check(n >= 4012 && n <= 4020, "power-up delay");
		check(clk_en === 1'b1 && ctrl_oe === 1'b1 && moe === 1'b0, "up");
		check(ad_low === 1'b0 && flush === 1'b0, "sec bus live");
		$display("test power-up done");
		cfg(1'b1, 8'h3e, 8'h00, 8'h40, 1'b1);
		repeat (2) @(negedge i_clk);
		check(srst_n === 1'b0 && ctrl_oe === 1'b0, "bit reset");
		check(ad_low === 1'b1 && flush === 1'b1, "ad low");
		cfg(1'b0, 8'h3e, 8'h40, 8'h40, 1'b1);
		cfg(1'b1, 8'h3e, 8'h00, 8'h00, 1'b1);
		wait_rel(n);
		check(n >= 4000 && n <= 4004, "bit delay");
		$display("test reset bit done");
		cfg(1'b1, 8'h41, 8'h00, 8'h01, 1'b1);
		cfg(1'b0, 8'h3e, 8'h00, 8'h00, 1'b0);
		check(srst_n === 1'b0 && pri_oe === 1'b0, "chip reset");
		repeat (18) @(negedge i_clk);
		cfg(1'b0, 8'h41, 8'h01, 8'h00, 1'b1);
		cfg(1'b0, 8'h3e, 8'h40, 8'h40, 1'b1);
		check(srst_n === 1'b0, "held");
		cfg(1'b1, 8'h3e, 8'h00, 8'h00, 1'b1);
		wait_rel(n);
		check(n >= 4000 && n <= 4004, "chip delay");
		$display("test chip reset done");
		for (int s = 1; s < 3; s++)
		begin
			cfg(1'b1, 8'h44, 8'h00, s[7:0], 1'b1);
			cfg(1'b0, 8'h44, 8'h03, 8'h00, 1'b1);
		end
		for (int b = 0; b < 2; b++)
		begin
			pcc_en = b[0];
			cfg(1'b1, 8'h44, 8'h00, 8'h03, 1'b1);
			cfg(1'b0, 8'h44, 8'h03, 8'h03, 1'b1);
			check(clk_en === ~b[0] && pwr === 2'h3, "d3hot");
			check(b2 === b[0], "b2");
			cfg(1'b1, 8'h44, 8'h00, 8'h00, 1'b1);
			bad = 1'b0;
			repeat (20) @(negedge i_clk)
				bad = bad | (srst_n !== 1'b1);
			check(!bad && clk_en === 1'b1, "wake");
			cfg(1'b0, 8'h44, 8'h03, 8'h00, 1'b1);
		end
		$display("test power states done");
		@(posedge i_clk);
		#5 i_nrst = 1'b0;
		#1 check(srst_n === 1'b0 && pri_oe === 1'b0, "async");
		repeat (2) @(negedge i_clk);
		i_nrst = 1'b1;
		wait_rel(n);
		check(n >= 4016 && n <= 4024, "second release");
		check(note_q.size() == 0, "unanswered");
		$display("test async reset done");
		print_verdict();
	end
endmodule
`default_nettype wire
